/* File: adct_cfg.svh */
// Timing and field constants for the converter timing controller
`ifndef ADCT_CFG_SVH
`define ADCT_CFG_SVH
// ==========================================
// Control register field positions and result codes
`define ADCT_STC_LSB        12
`define ADCT_CTC_LSB        14
`define ADCT_RES_BITS       10
`define ADCT_RES_ZERO       10'h000
`define ADCT_RES_FULL       10'h3FF
// ==========================================
// Phase lengths in half-cycle units, ctc 00
`define ADCT_S00_0          120
`define ADCT_S00_1          140
`define ADCT_S00_2          200
`define ADCT_S00_3          400
`define ADCT_C00_0          240
`define ADCT_C00_N          280
`define ADCT_E00_0          28
`define ADCT_E00_1          16
`define ADCT_E00_2          52
`define ADCT_E00_3          44
// Ctc 11
`define ADCT_S11_0          240
`define ADCT_S11_1          280
`define ADCT_S11_2          400
`define ADCT_S11_3          800
`define ADCT_C11_0          480
`define ADCT_C11_N          560
`define ADCT_E11_0          52
`define ADCT_E11_1          28
`define ADCT_E11_2          100
`define ADCT_E11_3          52
// Ctc 10
`define ADCT_S10_0          480
`define ADCT_S10_1          560
`define ADCT_S10_2          800
`define ADCT_S10_3          1600
`define ADCT_C10_0          960
`define ADCT_C10_N          1120
`define ADCT_E10_0          100
`define ADCT_E10_1          52
`define ADCT_E10_2          196
`define ADCT_E10_3          164
// Shortest total conversion
`define ADCT_MIN_TOTAL      388
// Half-cpu-period units per clock (cpu clock is 1/(2 units))
`define ADCT_UNITS_PER_CLK  2
`endif

/* File: adct_pkg.sv */
// Types for the converter timing controller
package adct_pkg;
   typedef enum logic [3:0] {
      ADCT_IDLE   = 4'b0001,
      ADCT_SAMPLE = 4'b0010,
      ADCT_COMP   = 4'b0100,
      ADCT_EXTRA  = 4'b1000
   } adct_state_t;
   typedef struct packed {
      logic [11:0] sample_len;
      logic [11:0] comp_len;
      logic [11:0] extra_len;
   } adct_len_t;
endpackage : adct_pkg

/* File: adct_len_lut.sv */
// Phase length lookup, in clock cycles, from the two timing codes
`include "adct_cfg.svh"
module adct_len_lut (
   input  wire logic [1:0]        conv_time_code,
   input  wire logic [1:0]        sample_time_code,
   output adct_pkg::adct_len_t    len
);
   // ==========================================
   // Lookup
   function automatic logic [11:0] cyc(input int units);
      cyc = 12'(units / `ADCT_UNITS_PER_CLK);
   endfunction : cyc

   adct_pkg::adct_len_t t00;
   adct_pkg::adct_len_t t11;
   adct_pkg::adct_len_t t10;

   always_comb begin
      case (sample_time_code)
         2'h0: t00 = '{cyc(`ADCT_S00_0), cyc(`ADCT_C00_0), cyc(`ADCT_E00_0)};
         2'h1: t00 = '{cyc(`ADCT_S00_1), cyc(`ADCT_C00_N), cyc(`ADCT_E00_1)};
         2'h2: t00 = '{cyc(`ADCT_S00_2), cyc(`ADCT_C00_N), cyc(`ADCT_E00_2)};
         default: t00 = '{cyc(`ADCT_S00_3), cyc(`ADCT_C00_N), cyc(`ADCT_E00_3)};
      endcase
      case (sample_time_code)
         2'h0: t11 = '{cyc(`ADCT_S11_0), cyc(`ADCT_C11_0), cyc(`ADCT_E11_0)};
         2'h1: t11 = '{cyc(`ADCT_S11_1), cyc(`ADCT_C11_N), cyc(`ADCT_E11_1)};
         2'h2: t11 = '{cyc(`ADCT_S11_2), cyc(`ADCT_C11_N), cyc(`ADCT_E11_2)};
         default: t11 = '{cyc(`ADCT_S11_3), cyc(`ADCT_C11_N), cyc(`ADCT_E11_3)};
      endcase
      case (sample_time_code)
         2'h0: t10 = '{cyc(`ADCT_S10_0), cyc(`ADCT_C10_0), cyc(`ADCT_E10_0)};
         2'h1: t10 = '{cyc(`ADCT_S10_1), cyc(`ADCT_C10_N), cyc(`ADCT_E10_1)};
         2'h2: t10 = '{cyc(`ADCT_S10_2), cyc(`ADCT_C10_N), cyc(`ADCT_E10_2)};
         default: t10 = '{cyc(`ADCT_S10_3), cyc(`ADCT_C10_N), cyc(`ADCT_E10_3)};
      endcase
   end

   // Reserved code 01 falls back to the 00 timing so a conversion always ends
   assign len = (conv_time_code == 2'b11) ? t11 :
                (conv_time_code == 2'b10) ? t10 : t00;
endmodule : adct_len_lut

/* File: adct_timing.sv */
// Successive-approximation conversion timing controller
`include "adct_cfg.svh"
module adct_timing (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   input  wire logic                   start,
   input  wire logic [15:0]            converter_control_reg,
   input  wire logic [9:0]             ain_level,
   input  wire logic                   ain_below_gnd,
   input  wire logic                   ain_above_ref,
   input  wire logic                   cmp_result,
   output logic                        sample_en,
   output logic                        hold,
   output logic [9:0]                  dac_code,
   output logic                        busy,
   output logic [9:0]                  result,
   output logic                        result_valid
);
   // ==========================================
   // Timing code decode
   wire logic [1:0] conv_time_code;
   wire logic [1:0] sample_time_code;
   adct_pkg::adct_len_t len;

   assign conv_time_code   = converter_control_reg[`ADCT_CTC_LSB +: 2];
   assign sample_time_code = converter_control_reg[`ADCT_STC_LSB +: 2];

   adct_len_lut u_lut (
      .conv_time_code   (conv_time_code),
      .sample_time_code (sample_time_code),
      .len              (len)
   );

   // ==========================================
   // Phase sequencer
   adct_pkg::adct_state_t state;
   adct_pkg::adct_state_t next_state;
   adct_pkg::adct_len_t   lat_len;
   logic [11:0]           cnt;
   logic [3:0]            bit_idx;
   logic [9:0]            sar;
   logic [9:0]            held;
   logic                  held_lo;
   logic                  held_hi;
   logic [11:0]           step_len;

   // Each of the ten steps takes an equal slice; the remainder lands on the last
   assign step_len = 12'(lat_len.comp_len / 12'd10);
   wire logic cnt_done  = (cnt == 12'd1);
   wire logic step_done = (state == adct_pkg::ADCT_COMP) &&
                          ((bit_idx == 4'd9) ? cnt_done : (cnt == (lat_len.comp_len
                          - 12'(step_len * 12'(bit_idx)) - step_len + 12'd1)));
   wire logic [9:0] trial = sar | (10'h200 >> bit_idx);

   always_comb begin
      next_state = state;
      case (state)
         adct_pkg::ADCT_IDLE:   if (start) next_state = adct_pkg::ADCT_SAMPLE;
         adct_pkg::ADCT_SAMPLE: if (cnt_done) next_state = adct_pkg::ADCT_COMP;
         adct_pkg::ADCT_COMP:   if (cnt_done) next_state = adct_pkg::ADCT_EXTRA;
         adct_pkg::ADCT_EXTRA:  if (cnt_done) next_state = adct_pkg::ADCT_IDLE;
         default:               next_state = adct_pkg::ADCT_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state   <= adct_pkg::ADCT_IDLE;
         cnt     <= 12'h000;
         lat_len <= '0;
      end else begin
         state <= next_state;
         if (state == adct_pkg::ADCT_IDLE && start) begin
            lat_len <= len;
            cnt     <= len.sample_len;
         end else if (state == adct_pkg::ADCT_SAMPLE && cnt_done) begin
            cnt <= lat_len.comp_len;
         end else if (state == adct_pkg::ADCT_COMP && cnt_done) begin
            cnt <= lat_len.extra_len;
         end else if (cnt != 12'h000) begin
            cnt <= cnt - 12'd1;
         end
      end
   end

   // ==========================================
   // Hold and approximation register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         held    <= 10'h000;
         held_lo <= 1'b0;
         held_hi <= 1'b0;
         sar     <= 10'h000;
         bit_idx <= 4'h0;
      end else if (state == adct_pkg::ADCT_SAMPLE) begin
         // Input tracked only while sampling; frozen afterwards
         held    <= ain_level;
         held_lo <= ain_below_gnd;
         held_hi <= ain_above_ref;
         sar     <= 10'h000;
         bit_idx <= 4'h0;
      end else if (step_done && bit_idx < 4'd10) begin
         sar     <= cmp_result ? trial : sar;
         bit_idx <= bit_idx + 4'd1;
      end
   end

   // ==========================================
   // Result transfer at end of extra phase
   wire logic       extra_end = (state == adct_pkg::ADCT_EXTRA) && cnt_done;
   wire logic [9:0] final_val = held_lo ? `ADCT_RES_ZERO :
                                held_hi ? `ADCT_RES_FULL : sar;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         result       <= 10'h000;
         result_valid <= 1'b0;
      end else begin
         result_valid <= extra_end;
         if (extra_end) result <= final_val;
      end
   end

   assign sample_en = (state == adct_pkg::ADCT_SAMPLE);
   assign hold      = (state == adct_pkg::ADCT_COMP) || (state == adct_pkg::ADCT_EXTRA);
   assign busy      = (state != adct_pkg::ADCT_IDLE);
   assign dac_code  = (bit_idx < 4'd10) ? trial : sar;

   // ==========================================
   // Checks
   logic [11:0] tot;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) tot <= 12'h000;
      else if (!busy) tot <= 12'h000;
      else tot <= tot + 12'd1;
   end

   min_total_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      extra_end |-> tot >= 12'(`ADCT_MIN_TOTAL / `ADCT_UNITS_PER_CLK) - 12'd1)
      else $error("conversion shorter than minimum");
   total_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      extra_end |-> tot + 12'd1 == lat_len.sample_len + lat_len.comp_len + lat_len.extra_len)
      else $error("total differs from phase sum");
   sample_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state == adct_pkg::ADCT_IDLE && start) |=> sample_en)
      else $error("conversion did not begin with sampling");
   sample_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(sample_en) |-> cnt == lat_len.sample_len)
      else $error("sample length not loaded");
   steps_done_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(state == adct_pkg::ADCT_EXTRA) |-> bit_idx == 4'd10)
      else $error("not all ten steps taken");
   held_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (hold && $past(hold)) |-> $stable(held))
      else $error("held value changed after sampling");
   clamp_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (extra_end && held_lo) |=> result == `ADCT_RES_ZERO)
      else $error("underrange result not zero");
   clamp_full_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (extra_end && !held_lo && held_hi) |=> result == `ADCT_RES_FULL)
      else $error("overrange result not full scale");
   lut_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (converter_control_reg[15:12] == 4'h0) |-> len.sample_len == 12'd60 && len.comp_len == 12'd120)
      else $error("fastest code lengths wrong");

   conv_done_c: cover property (@(posedge clk_sys) disable iff (!rst_b) result_valid);
   slow_code_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      extra_end && conv_time_code == 2'b10);
   clamp_c:     cover property (@(posedge clk_sys) disable iff (!rst_b) extra_end && held_hi);
endmodule : adct_timing

/* File: adct_src_model.sv */
// Analog source and comparator model for the converter timing controller
// ==========================================
// Source model
module adct_src_model (
   input  wire logic       clk_sys,
   input  wire logic [9:0] src_level,
   input  wire logic       src_below,
   input  wire logic       src_above,
   input  wire logic       sample_en,
   input  wire logic [9:0] dac_code,
   output logic [9:0]      ain_level,
   output logic            ain_below_gnd,
   output logic            ain_above_ref,
   output logic            cmp_result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held;
   initial held = 10'h000;
   // Capacitor follows the pin only while sampling
   always @(posedge clk_sys) if (sample_en) held <= src_level;
   assign ain_level = src_level;
   assign ain_below_gnd = src_below;
   assign ain_above_ref = src_above;
   // Comparator judges the held charge, so late pin changes cannot leak in
   assign cmp_result = (held >= dac_code);
endmodule : adct_src_model

/* File: test_adct_timing.sv */
// Self-checking bench for the converter timing controller
module test_adct_timing;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Signals
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        start = 1'b0;
   logic [15:0] converter_control_reg = 16'h0000;
   logic [9:0]  src_level = 10'h000;
   logic        src_below = 1'b0;
   logic        src_above = 1'b0;
   logic [9:0]  ain_level, dac_code, result, fd, res;
   logic        ain_below_gnd, ain_above_ref, cmp_result, sample_en, hold, busy, result_valid;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          tot, smp, hld;
   // Units per code pair: ctc 00, 11, 10, each with stc 00 to 11
   int          smp_u[12] = '{120, 140, 200, 400, 240, 280, 400, 800, 480, 560, 800, 1600};
   int          rest_u[12] = '{268, 296, 332, 324, 532, 588, 660, 612, 1060, 1172, 1316, 1284};
   always #4 clk_sys = ~clk_sys;
   adct_timing adct_timing_inst (.clk_sys(clk_sys), .rst_b(rst_b), .start(start),
      .converter_control_reg(converter_control_reg), .ain_level(ain_level),
      .ain_below_gnd(ain_below_gnd), .ain_above_ref(ain_above_ref), .cmp_result(cmp_result),
      .sample_en(sample_en), .hold(hold), .dac_code(dac_code), .busy(busy), .result(result),
      .result_valid(result_valid));
   adct_src_model adct_src_model_inst (.clk_sys(clk_sys), .src_level(src_level),
      .src_below(src_below), .src_above(src_above), .sample_en(sample_en),
      .dac_code(dac_code), .ain_level(ain_level), .ain_below_gnd(ain_below_gnd),
      .ain_above_ref(ain_above_ref), .cmp_result(cmp_result));
   // ==========================================
   // Helpers
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   // One conversion, phases measured on falling edges; the first hold cycle
   // swaps the pin level and the codes, and may raise start, all of which must be ignored
   task conv(input logic [3:0] codes, input logic [9:0] lvl, input logic [9:0] lvl2,
             input logic b, input logic a, input logic mid);
      @(negedge clk_sys);
      converter_control_reg = {codes, 12'h000};
      src_level = lvl;
      src_below = b;
      src_above = a;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      tot = 0;
      smp = 0;
      hld = 0;
      chk(busy === 1'b1, "busy not raised");
      while (tot < 2000 && result_valid !== 1'b1) begin
         smp += (sample_en === 1'b1);
         if (hold === 1'b1 && hld == 0) begin
            fd = dac_code;
            src_level = lvl2;
            start = mid;
            converter_control_reg = 16'hF000;
         end
         hld += (hold === 1'b1);
         @(negedge clk_sys);
         tot++;
      end
      res = result;
      start = 1'b0;
      chk(busy === 1'b0, "busy after result");
   endtask : conv
   // ==========================================
   // Scenarios
   task t_table;
      // Reserved conv_time_code 01 is never programmed
      for (int i = 0; i < 12; i++) begin
         conv({(i < 4) ? 2'b00 : (i < 8) ? 2'b11 : 2'b10, 2'(i % 4)}, 10'(i * 83 + 7),
              10'(i * 83 + 7), 1'b0, 1'b0, 1'b0);
         chk(smp == smp_u[i] / 2, "sample length");
         chk(hld == rest_u[i] / 2, "comparison and extra length");
         chk(tot == (smp_u[i] + rest_u[i]) / 2, "total length");
         chk(fd === 10'h200, "first trial code");
         chk(res === 10'(i * 83 + 7), "result code");
      end
      $display("t_table done");
   endtask : t_table
   task t_min;
      conv(4'h0, 10'h3FE, 10'h3FE, 1'b0, 1'b0, 1'b0);
      chk(tot == 388 / 2, "shortest conversion");
      chk(res === 10'h3FE, "result code");
      $display("t_min done");
   endtask : t_min
   task t_hold;
      conv(4'hD, 10'h155, 10'h3AA, 1'b0, 1'b0, 1'b0);
      chk(res === 10'h155, "held sample");
      $display("t_hold done");
   endtask : t_hold
   task t_clamp;
      conv(4'h0, 10'h3FF, 10'h3FF, 1'b1, 1'b0, 1'b0);
      chk(res === 10'h000, "below ground");
      conv(4'h0, 10'h000, 10'h000, 1'b0, 1'b1, 1'b0);
      chk(res === 10'h3FF, "above reference");
      $display("t_clamp done");
   endtask : t_clamp
   task t_refuse;
      conv(4'h3, 10'h0F0, 10'h0F0, 1'b0, 1'b0, 1'b1);
      chk(tot == (400 + 324) / 2, "start while busy");
      chk(res === 10'h0F0, "result code");
      repeat (3) @(negedge clk_sys);
      chk(busy === 1'b0 && result_valid === 1'b0, "no hidden restart");
      $display("t_refuse done");
   endtask : t_refuse
   // ==========================================
   // Run control
   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      t_min();
      t_table();
      t_hold();
      t_clamp();
      t_refuse();
      conclude();
   end
   // Tests need about 9000 cycles; twice that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      conclude();
   end
endmodule : test_adct_timing
